// *** hw/unm_defines.svh ***
`ifndef UNM_DEFINES_SVH
`define UNM_DEFINES_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UNM_OFS_CTRL   8'hf0
`define UNM_OFS_PEND   8'hf4
`define UNM_OFS_MASK   8'hec
`define UNM_OFS_DATA   8'hf8
`define UNM_OFS_BAUD   8'hfc
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UNM_CTRL_MODE_HI 7
`define UNM_CTRL_MODE_LO 6
`define UNM_CTRL_MCE     5
`define UNM_CTRL_RE      4
`define UNM_CTRL_TB8     3
`define UNM_CTRL_RB8     2
`define UNM_CTRL_PAR     0
`define UNM_PEND_TX      0
`define UNM_PEND_RX      1
`define UNM_PEND_OVR     2
// ----------------------------------------------------------------
// Reset values, timing counts and response codes
// ----------------------------------------------------------------
`define UNM_CTRL_RST   8'h00
`define UNM_BAUD_RST   8'h00
`define UNM_SUB_LAST   4'hf
`define UNM_SUB_MID    4'h7
`define UNM_RESP_OKAY  2'h0
`define UNM_RESP_SLV   2'h2
`endif

// *** hw/unm_pkg.sv ***
`default_nettype none
package unm_pkg;
    typedef enum logic [1:0] {
        UNM_MODE_SHIFT = 2'h0,
        UNM_MODE_8VAR  = 2'h1,
        UNM_MODE_9FIX  = 2'h2,
        UNM_MODE_9VAR  = 2'h3
    } unm_mode_t;
    typedef enum logic [1:0] {
        UNM_TX_IDLE  = 2'h0,
        UNM_TX_SHIFT = 2'h1,
        UNM_TX_STOP  = 2'h3
    } unm_tx_state_t;
    typedef enum logic [1:0] {
        UNM_RX_IDLE  = 2'h0,
        UNM_RX_START = 2'h1,
        UNM_RX_DATA  = 2'h3,
        UNM_RX_STOP  = 2'h2
    } unm_rx_state_t;
endpackage : unm_pkg
`default_nettype wire

// *** hw/unm_baud_gen.sv ***
`default_nettype none
// ----------------------------------------------------------------
// Sixteen-times bit clock enable
// ----------------------------------------------------------------
module unm_baud_gen #(
    parameter int DIV_W = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             fixed_rate,
    output logic                  tick16
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic             tick_reg;
    logic             tick_next;

    generate
        if (DIV_W < 2) begin : g_chk
            $error("DIV_W must be at least 2");
        end
    endgenerate

    always_comb begin
        tick_next = fixed_rate || (cnt_reg == divisor);
        cnt_next  = tick_next ? '0 : cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick16 = tick_reg;
endmodule : unm_baud_gen
`default_nettype wire

// *** hw/unm_top.sv ***
// Our own choice: register access over AXI4-Lite.
`default_nettype none
`include "unm_defines.svh"
module unm_top
    import unm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              rxd,
    output logic                   txd,
    output logic                   irq
);
    generate
        if (ADDR_W != 8) begin : g_chk
            $error("ADDR_W must be 8");
        end
    endgenerate
// ----------------------------------------------------------------
// Bus slave
// ----------------------------------------------------------------
    logic [7:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic       aw_ok_reg, aw_ok_next, w_ok_reg, w_ok_next, wstb_reg, wstb_next;
    logic       bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic       wr_en, wr_hit, rd_hit;
    logic [7:0] rd_val;
    logic [7:0] ctrl_reg, ctrl_next, baud_reg, baud_next, rxbuf_reg, rxbuf_next;
    logic [2:0] pend_reg, pend_next, mask_reg, mask_next, pend_set, pend_clr;
    unm_mode_t  mode;

    assign wr_en  = aw_ok_reg && w_ok_reg && !bvalid_reg;
    assign wr_hit = awaddr_reg inside {`UNM_OFS_CTRL, `UNM_OFS_PEND, `UNM_OFS_MASK,
                                       `UNM_OFS_DATA, `UNM_OFS_BAUD};

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `UNM_OFS_CTRL: rd_val = ctrl_reg;
            `UNM_OFS_PEND: rd_val = {5'h00, pend_reg};
            `UNM_OFS_MASK: rd_val = {5'h00, mask_reg};
            `UNM_OFS_DATA: rd_val = rxbuf_reg;
            `UNM_OFS_BAUD: rd_val = baud_reg;
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        awaddr_next = awaddr_reg;
        aw_ok_next  = aw_ok_reg;
        wdata_next  = wdata_reg;
        wstb_next   = wstb_reg;
        w_ok_next   = w_ok_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (s_axi_awvalid && !aw_ok_reg) begin
            aw_ok_next  = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ok_reg) begin
            w_ok_next  = 1'b1;
            wdata_next = s_axi_wdata[7:0];
            wstb_next  = s_axi_wstrb[0];
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_en) begin
            aw_ok_next  = 1'b0;
            w_ok_next   = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = wr_hit ? `UNM_RESP_OKAY : `UNM_RESP_SLV;
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_val;
            rresp_next  = rd_hit ? `UNM_RESP_OKAY : `UNM_RESP_SLV;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            awaddr_reg <= 8'h00;
            aw_ok_reg  <= 1'b0;
            wdata_reg  <= 8'h00;
            wstb_reg   <= 1'b0;
            w_ok_reg   <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= 2'h0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= 8'h00;
            rresp_reg  <= 2'h0;
        end else begin
            awaddr_reg <= awaddr_next;
            aw_ok_reg  <= aw_ok_next;
            wdata_reg  <= wdata_next;
            wstb_reg   <= wstb_next;
            w_ok_reg   <= w_ok_next;
            bvalid_reg <= bvalid_next;
            bresp_reg  <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    assign s_axi_awready = !aw_ok_reg;
    assign s_axi_wready  = !w_ok_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = {24'h000000, rdata_reg};
    assign s_axi_rresp   = rresp_reg;
// ----------------------------------------------------------------
// Control, pending, mask, baud and data registers
// ----------------------------------------------------------------
    logic wr_ctrl, wr_pend, wr_mask, wr_data, wr_baud, tick16;
    logic nine, par_on, filt_on, rx_load, rx_ninth, tx_set;
    logic [7:0] rx_byte;

    assign wr_ctrl = wr_en && wstb_reg && (awaddr_reg == `UNM_OFS_CTRL);
    assign wr_pend = wr_en && wstb_reg && (awaddr_reg == `UNM_OFS_PEND);
    assign wr_mask = wr_en && wstb_reg && (awaddr_reg == `UNM_OFS_MASK);
    assign wr_data = wr_en && wstb_reg && (awaddr_reg == `UNM_OFS_DATA);
    assign wr_baud = wr_en && wstb_reg && (awaddr_reg == `UNM_OFS_BAUD);
    assign mode    = unm_mode_t'(ctrl_reg[`UNM_CTRL_MODE_HI:`UNM_CTRL_MODE_LO]);
    assign nine    = mode[1];
    assign par_on  = ctrl_reg[`UNM_CTRL_PAR];
    assign filt_on = ctrl_reg[`UNM_CTRL_MCE] && nine && !par_on;
    assign pend_clr = wr_pend ? wdata_reg[2:0] : 3'h0;

    always_comb begin
        ctrl_next  = ctrl_reg;
        baud_next  = baud_reg;
        mask_next  = mask_reg;
        rxbuf_next = rxbuf_reg;
        if (wr_ctrl) begin
            ctrl_next = {wdata_reg[7:3], ctrl_reg[`UNM_CTRL_RB8], wdata_reg[1:0]};
        end
        if (wr_baud) begin
            baud_next = wdata_reg;
        end
        if (wr_mask) begin
            mask_next = wdata_reg[2:0];
        end
        if (rx_load) begin
            rxbuf_next = rx_byte;
            ctrl_next[`UNM_CTRL_RB8] = rx_ninth;
        end
        pend_next = (pend_reg & ~pend_clr) | pend_set;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_reg  <= `UNM_CTRL_RST;
            baud_reg  <= `UNM_BAUD_RST;
            mask_reg  <= 3'h0;
            pend_reg  <= 3'h0;
            rxbuf_reg <= 8'h00;
        end else begin
            ctrl_reg  <= ctrl_next;
            baud_reg  <= baud_next;
            mask_reg  <= mask_next;
            pend_reg  <= pend_next;
            rxbuf_reg <= rxbuf_next;
        end
    end

    assign irq = |(pend_reg & mask_reg);

    unm_baud_gen #(
        .DIV_W (8)
    ) u_unm_baud_gen (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .divisor    (baud_reg),
        .fixed_rate (mode == UNM_MODE_9FIX),
        .tick16     (tick16)
    );
// ----------------------------------------------------------------
// Transmitter
// ----------------------------------------------------------------
    unm_tx_state_t tx_state_reg, tx_state_next;
    logic [10:0] tx_frame_reg, tx_frame_next;
    logic [3:0]  tx_sub_reg, tx_sub_next, tx_cnt_reg, tx_cnt_next, tx_nb_reg, tx_nb_next;
    logic        txd_reg, txd_next, tx_ninth;

    assign tx_ninth = par_on ? ^wdata_reg : ctrl_reg[`UNM_CTRL_TB8];

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_frame_next = tx_frame_reg;
        tx_sub_next   = tx_sub_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_nb_next    = tx_nb_reg;
        txd_next      = txd_reg;
        tx_set        = 1'b0;
        if (wr_data) begin
            tx_state_next = UNM_TX_SHIFT;
            tx_sub_next   = 4'h0;
            tx_cnt_next   = 4'h0;
            case (mode)
                UNM_MODE_SHIFT: begin
                    tx_frame_next = {3'h7, wdata_reg};
                    tx_nb_next    = 4'h8;
                end
                UNM_MODE_8VAR: begin
                    tx_frame_next = {2'h3, wdata_reg, 1'b0};
                    tx_nb_next    = 4'h9;
                end
                default: begin
                    tx_frame_next = {1'b1, tx_ninth, wdata_reg, 1'b0};
                    tx_nb_next    = 4'ha;
                end
            endcase
            txd_next = tx_frame_next[0];
        end else if (tick16) begin
            case (tx_state_reg)
                UNM_TX_SHIFT: begin
                    tx_sub_next = tx_sub_reg + 4'h1;
                    if (tx_sub_reg == `UNM_SUB_LAST) begin
                        tx_frame_next = {1'b1, tx_frame_reg[10:1]};
                        tx_cnt_next   = tx_cnt_reg + 4'h1;
                        txd_next      = tx_frame_reg[1];
                        if (tx_cnt_reg == tx_nb_reg - 4'h1) begin
                            tx_set        = 1'b1;
                            txd_next      = 1'b1;
                            tx_state_next = (tx_nb_reg == 4'h8) ? UNM_TX_IDLE : UNM_TX_STOP;
                        end
                    end
                end
                UNM_TX_STOP: begin
                    tx_sub_next = tx_sub_reg + 4'h1;
                    if (tx_sub_reg == `UNM_SUB_LAST) begin
                        tx_state_next = UNM_TX_IDLE;
                    end
                end
                default: begin
                    txd_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_state_reg <= UNM_TX_IDLE;
            tx_frame_reg <= 11'h7ff;
            tx_sub_reg   <= 4'h0;
            tx_cnt_reg   <= 4'h0;
            tx_nb_reg    <= 4'ha;
            txd_reg      <= 1'b1;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_frame_reg <= tx_frame_next;
            tx_sub_reg   <= tx_sub_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_nb_reg    <= tx_nb_next;
            txd_reg      <= txd_next;
        end
    end

    assign txd = txd_reg;
// ----------------------------------------------------------------
// Receiver
// ----------------------------------------------------------------
    unm_rx_state_t rx_state_reg, rx_state_next;
    logic [8:0] rx_shift_reg, rx_shift_next;
    logic [3:0] rx_sub_reg, rx_sub_next, rx_cnt_reg, rx_cnt_next;
    logic       rx_nine_reg, rx_nine_next, rxd_meta_reg, rxd_sync_reg, rxd_prev_reg;
    logic       rx_done, rx_accept;

    assign rx_done  = (rx_state_reg == UNM_RX_STOP) && tick16 &&
                      (rx_sub_reg == `UNM_SUB_LAST);
    assign rx_byte  = rx_nine_reg ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
    assign rx_ninth = rx_nine_reg ? rx_shift_reg[8] : rxd_sync_reg;
    assign rx_accept = rx_nine_reg ? !(filt_on && !rx_shift_reg[8])
                     : (!ctrl_reg[`UNM_CTRL_MCE] || rxd_sync_reg);
    assign rx_load  = rx_done && rx_accept;
    assign pend_set = {rx_load && pend_reg[`UNM_PEND_RX], rx_load, tx_set};

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_shift_next = rx_shift_reg;
        rx_sub_next   = rx_sub_reg;
        rx_cnt_next   = rx_cnt_reg;
        rx_nine_next  = rx_nine_reg;
        case (rx_state_reg)
            UNM_RX_IDLE: begin
                if (ctrl_reg[`UNM_CTRL_RE] && (mode != UNM_MODE_SHIFT) &&
                    rxd_prev_reg && !rxd_sync_reg) begin
                    rx_state_next = UNM_RX_START;
                    rx_sub_next   = 4'h0;
                    rx_nine_next  = nine;
                end
            end
            UNM_RX_START: begin
                if (tick16) begin
                    rx_sub_next = rx_sub_reg + 4'h1;
                    if (rx_sub_reg == `UNM_SUB_MID) begin
                        rx_sub_next   = 4'h0;
                        rx_cnt_next   = 4'h0;
                        rx_state_next = rxd_sync_reg ? UNM_RX_IDLE : UNM_RX_DATA;
                    end
                end
            end
            UNM_RX_DATA: begin
                if (tick16) begin
                    rx_sub_next = rx_sub_reg + 4'h1;
                    if (rx_sub_reg == `UNM_SUB_LAST) begin
                        rx_shift_next = {rxd_sync_reg, rx_shift_reg[8:1]};
                        rx_cnt_next   = rx_cnt_reg + 4'h1;
                        if (rx_cnt_reg == (rx_nine_reg ? 4'h8 : 4'h7)) begin
                            rx_state_next = UNM_RX_STOP;
                        end
                    end
                end
            end
            UNM_RX_STOP: begin
                if (tick16) begin
                    rx_sub_next = rx_sub_reg + 4'h1;
                end
                if (rx_done) begin
                    rx_state_next = UNM_RX_IDLE;
                end
            end
            default: begin
                rx_state_next = UNM_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_state_reg <= UNM_RX_IDLE;
            rx_shift_reg <= 9'h000;
            rx_sub_reg   <= 4'h0;
            rx_cnt_reg   <= 4'h0;
            rx_nine_reg  <= 1'b0;
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
            rxd_prev_reg <= 1'b1;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_shift_reg <= rx_shift_next;
            rx_sub_reg   <= rx_sub_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_nine_reg  <= rx_nine_next;
            rxd_meta_reg <= rxd;
            rxd_sync_reg <= rxd_meta_reg;
            rxd_prev_reg <= rxd_sync_reg;
        end
    end
// ----------------------------------------------------------------
// Assertions
// ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_TX_START: assert property (wr_data && mode != UNM_MODE_SHIFT |=> !txd ##1 !txd)
        else $error("start bit not driven after data write");
    AST_TX_NINTH: assert property (wr_data && nine && !par_on
        |=> tx_frame_reg[9] == $past(ctrl_reg[`UNM_CTRL_TB8]))
        else $error("ninth bit differs from control");
    AST_TX_STOP: assert property (tx_set && tx_nb_reg != 4'h8
        |=> txd && tx_state_reg == UNM_TX_STOP && pend_reg[`UNM_PEND_TX])
        else $error("stop bit and pending mismatch");
    AST_FILTER: assert property (rx_done && filt_on && !rx_shift_reg[8]
        |=> !$rose(pend_reg[`UNM_PEND_RX]))
        else $error("filtered frame raised receive pending");
    AST_RB8: assert property (rx_load && rx_nine_reg
        |=> ctrl_reg[`UNM_CTRL_RB8] == $past(rx_shift_reg[8]) && pend_reg[`UNM_PEND_RX])
        else $error("ninth bit not stored");
    AST_STOP_CHECK: assert property (rx_done && !rx_nine_reg &&
        ctrl_reg[`UNM_CTRL_MCE] && !rxd_sync_reg |=> !$rose(pend_reg[`UNM_PEND_RX]))
        else $error("bad stop bit raised receive pending");
    AST_FALSE_START: assert property (rx_state_reg == UNM_RX_START && tick16 &&
        rx_sub_reg == `UNM_SUB_MID && rxd_sync_reg |=> rx_state_reg == UNM_RX_IDLE)
        else $error("false start not rejected");
    AST_OVERRUN: assert property (rx_load && pend_reg[`UNM_PEND_RX]
        |=> pend_reg[`UNM_PEND_OVR] && rxbuf_reg == $past(rx_byte))
        else $error("overrun not flagged");
    AST_FIXED_RATE: assert property (mode == UNM_MODE_9FIX && $past(mode) == UNM_MODE_9FIX
        |-> tick16)
        else $error("fixed rate tick missing");
    AST_SHIFT_IDLE: assert property (rx_state_reg == UNM_RX_IDLE &&
        mode == UNM_MODE_SHIFT |=> rx_state_reg == UNM_RX_IDLE)
        else $error("receiver left idle in shift mode");

    COV_TX_DONE: cover property (tx_state_reg == UNM_TX_STOP ##1 tx_state_reg == UNM_TX_IDLE);
    COV_ADDR: cover property (rx_load && rx_nine_reg && rx_shift_reg[8] && filt_on);
    COV_FILTERED: cover property (rx_done && !rx_accept);
    COV_OVERRUN: cover property (rx_load && pend_reg[`UNM_PEND_RX]);
endmodule : unm_top
`default_nettype wire

// *** dv/unm_serial_node.sv ***
`default_nettype none
// ----
// Far serial node
// ----
module unm_serial_node #(
    parameter int BIT_CLKS = 32
) (
    input  wire logic ref_clk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] cap;
    int         frames = 0;
    int         bit_clks = BIT_CLKS;
    initial rxd = 1'h1;
    task automatic send_frame(input logic [7:0] d, input logic ninth);
        logic [10:0] b;
        b = {1'h1, ninth, d, 1'h0};
        for (int i = 0; i < 11; i++) begin
            rxd <= b[i];
            repeat (bit_clks) @(posedge ref_clk);
        end
    endtask : send_frame
    always begin
        @(negedge txd);
        repeat (bit_clks / 2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (bit_clks) @(posedge ref_clk);
            cap[i] = txd;
        end
        repeat (bit_clks) @(posedge ref_clk);
        if (txd === 1'h1) frames++;
    end
endmodule : unm_serial_node
`default_nettype wire

// *** dv/test_uart_nine_bit_multiproc.sv ***
`default_nettype none
`include "unm_defines.svh"
module test_uart_nine_bit_multiproc
    import unm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'h0, rst_n = 1'h0, rxd, txd, irq;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [8:0]  txv [2] = '{9'h1a5, 9'h03c};
    int          num_errors = 0, checked = 0;
    always #10 ref_clk = ~ref_clk;
    unm_top u_unm_top (.ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rxd(rxd), .txd(txd), .irq(irq));
    unm_serial_node #(.BIT_CLKS(32)) u_unm_serial_node (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
    // ----
    // Tasks
    // ----
    task automatic final_report;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic tmo(input logic ok);
        if (!ok) begin
            chk("wait done", 32'h1, 32'h0);
            final_report();
        end
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, bd;
        int n;
        bd = 1'h0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 400 && !bd; n++) begin
            @(negedge ref_clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            bd = bvalid;
            if (bd) chk("bresp", {30'h0, er}, {30'h0, bresp});
            @(posedge ref_clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (bd) bready <= 1'h0;
        end
        tmo(bd);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ta, td;
        int n;
        td = 1'h0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 400 && !td; n++) begin
            @(negedge ref_clk);
            ta = arvalid & arready;
            td = rvalid;
            if (td) chk("rresp", {30'h0, er}, {30'h0, rresp});
            if (td) chk("rdata", {24'h0, e}, rdata);
            @(posedge ref_clk);
            if (ta) arvalid <= 1'h0;
            if (td) rready <= 1'h0;
        end
        tmo(td);
    endtask : rc
    task automatic ci(input logic e);
        @(negedge ref_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : ci
    task automatic wt(input int f);
        for (int n = 0; n < 1000 && u_unm_serial_node.frames != f; n++) @(posedge ref_clk);
        tmo(u_unm_serial_node.frames == f);
    endtask : wt
    // ----
    // Sequence
    // ----
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        rc(`UNM_OFS_CTRL, 8'h00, `UNM_RESP_OKAY);
        rc(`UNM_OFS_BAUD, 8'h00, `UNM_RESP_OKAY);
        rc(8'hf1, 8'h00, `UNM_RESP_SLV);
        wr(8'he0, 8'h55, `UNM_RESP_SLV);
        ci(1'h0);
        $display("test regs done");
        wr(`UNM_OFS_BAUD, 8'h01, `UNM_RESP_OKAY);
        wr(`UNM_OFS_MASK, 8'h01, `UNM_RESP_OKAY);
        for (int i = 0; i < 2; i++) begin
            wr(`UNM_OFS_PEND, 8'h07, `UNM_RESP_OKAY);
            wr(`UNM_OFS_CTRL, {4'hc, txv[i][8], 3'h0}, `UNM_RESP_OKAY);
            wr(`UNM_OFS_DATA, txv[i][7:0], `UNM_RESP_OKAY);
            wt(i + 1);
            chk("tx frame", {23'h0, txv[i]}, {23'h0, u_unm_serial_node.cap});
            ci(1'h1);
            rc(`UNM_OFS_PEND, 8'h01, `UNM_RESP_OKAY);
        end
        u_unm_serial_node.bit_clks = 16;
        wr(`UNM_OFS_CTRL, 8'h88, `UNM_RESP_OKAY);
        wr(`UNM_OFS_DATA, 8'h96, `UNM_RESP_OKAY);
        wt(3);
        chk("fixed frame", 32'h196, {23'h0, u_unm_serial_node.cap});
        u_unm_serial_node.bit_clks = 32;
        $display("test tx done");
        wr(`UNM_OFS_MASK, 8'h02, `UNM_RESP_OKAY);
        wr(`UNM_OFS_PEND, 8'h07, `UNM_RESP_OKAY);
        wr(`UNM_OFS_CTRL, 8'hf0, `UNM_RESP_OKAY);
        u_unm_serial_node.send_frame(8'h5a, 1'h1);
        rc(`UNM_OFS_PEND, 8'h02, `UNM_RESP_OKAY);
        ci(1'h1);
        rc(`UNM_OFS_CTRL, 8'hf4, `UNM_RESP_OKAY);
        rc(`UNM_OFS_DATA, 8'h5a, `UNM_RESP_OKAY);
        wr(`UNM_OFS_PEND, 8'h02, `UNM_RESP_OKAY);
        u_unm_serial_node.send_frame(8'h33, 1'h0);
        rc(`UNM_OFS_PEND, 8'h00, `UNM_RESP_OKAY);
        ci(1'h0);
        wr(`UNM_OFS_CTRL, 8'hd0, `UNM_RESP_OKAY);
        u_unm_serial_node.send_frame(8'h33, 1'h0);
        rc(`UNM_OFS_CTRL, 8'hd0, `UNM_RESP_OKAY);
        u_unm_serial_node.send_frame(8'h44, 1'h0);
        rc(`UNM_OFS_PEND, 8'h06, `UNM_RESP_OKAY);
        rc(`UNM_OFS_DATA, 8'h44, `UNM_RESP_OKAY);
        $display("test rx done");
        wr(`UNM_OFS_PEND, 8'h07, `UNM_RESP_OKAY);
        wr(`UNM_OFS_CTRL, 8'hf1, `UNM_RESP_OKAY);
        u_unm_serial_node.send_frame(8'h12, 1'h0);
        rc(`UNM_OFS_PEND, 8'h02, `UNM_RESP_OKAY);
        rc(`UNM_OFS_DATA, 8'h12, `UNM_RESP_OKAY);
        wr(`UNM_OFS_PEND, 8'h07, `UNM_RESP_OKAY);
        wr(`UNM_OFS_CTRL, 8'h70, `UNM_RESP_OKAY);
        u_unm_serial_node.send_frame(8'h11, 1'h0);
        rc(`UNM_OFS_PEND, 8'h00, `UNM_RESP_OKAY);
        u_unm_serial_node.send_frame(8'h22, 1'h1);
        rc(`UNM_OFS_PEND, 8'h02, `UNM_RESP_OKAY);
        rc(`UNM_OFS_DATA, 8'h22, `UNM_RESP_OKAY);
        wr(`UNM_OFS_PEND, 8'h07, `UNM_RESP_OKAY);
        wr(`UNM_OFS_CTRL, 8'h30, `UNM_RESP_OKAY);
        u_unm_serial_node.send_frame(8'h66, 1'h1);
        rc(`UNM_OFS_PEND, 8'h00, `UNM_RESP_OKAY);
        wr(`UNM_OFS_DATA, 8'hff, `UNM_RESP_OKAY);
        repeat (300) @(posedge ref_clk);
        rc(`UNM_OFS_PEND, 8'h01, `UNM_RESP_OKAY);
        $display("test modes done");
        final_report();
    end
endmodule : test_uart_nine_bit_multiproc
`default_nettype wire
